// ### inc/ispfc_pkg.sv
// constants and types for the instrument serial port with rts/cts pacing
// assumes a single 25 MHz system clock and a fixed 8-N-1 frame
package ispfc_pkg;

  // clock and oversampling
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned OVS         = 16;
  localparam logic [3:0]  TICK_MID    = 4'h7;
  localparam logic [3:0]  TICK_LAST   = 4'hF;

  // selectable rates, index into the table below
  localparam int          NUM_RATES   = 10;
  localparam int unsigned RATE_BAUD [NUM_RATES] = '{
    75, 110, 150, 300, 600, 1200, 2400, 4800, 9600, 19200
  };
  localparam logic [3:0]  RATE_IDX_RESET = 4'h8;
  localparam logic [3:0]  RATE_IDX_MAX   = 4'h9;
  localparam int          DIV_W          = 16;

  // frame and buffer
  localparam int          DATA_BITS   = 8;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam int          RX_DEPTH_D  = 4;
  localparam logic [7:0]  LINE_TERM   = 8'h0A;

  typedef enum logic [1:0] {
    ISPFC_RX_IDLE,
    ISPFC_RX_START,
    ISPFC_RX_DATA,
    ISPFC_RX_STOP
  } ispfc_rx_state_t;

  typedef enum logic [1:0] {
    ISPFC_TX_IDLE,
    ISPFC_TX_START,
    ISPFC_TX_DATA,
    ISPFC_TX_STOP
  } ispfc_tx_state_t;

endpackage

// ### rtl/ispfc_serial_port.sv
// serial port core: baud generator, receiver with small buffer, transmitter
// assumes pins are synchronous to ref_clk; command decoding lives upstream
`timescale 1ns/100ps
`default_nettype none
module ispfc_serial_port
  import ispfc_pkg::*;
#(
  parameter int RX_DEPTH = RX_DEPTH_D
) (
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // serial pins
  input  wire logic       rxd,
  output logic            txd,
  output logic            rts_n,
  input  wire logic       cts_n,
  // rate settings
  input  wire logic [3:0] baud_sel,
  input  wire logic       baud_load,
  input  wire logic       settings_reset,
  // mode and remote control
  input  wire logic       talk_only,
  input  wire logic       parallel_active,
  input  wire logic       remote_enter,
  input  wire logic       go_local,
  output logic            remote,
  // received characters
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_pop,
  input  wire logic       validate_done,
  // characters to send
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(RX_DEPTH);
  // baud generator
  logic [DIV_W-1:0] div_tab [NUM_RATES];
  logic [3:0]       baud_idx_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic             tick_q;
  for (genvar r = 0; r < NUM_RATES; r++) begin : g_div
    assign div_tab[r] = DIV_W'(CLK_HZ / (OVS * RATE_BAUD[r]) - 1);
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_idx_q <= RATE_IDX_RESET;
    end else if (clk_en && settings_reset) begin
      baud_idx_q <= RATE_IDX_RESET;
    end else if (clk_en && baud_load && baud_sel <= RATE_IDX_MAX) begin
      baud_idx_q <= baud_sel;
    end
  end
  // one tick drives both directions, so rx and tx always share the rate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else if (clk_en) begin
      if (div_cnt_q == '0 || baud_load || settings_reset) begin
        div_cnt_q <= div_tab[baud_idx_q];
      end else begin
        div_cnt_q <= div_cnt_q - 1'b1;
      end
      tick_q <= (div_cnt_q == '0);
    end
  end
  // receiver
  ispfc_rx_state_t rx_st_q;
  logic [3:0]      rx_tcnt_q;
  logic [2:0]      rx_bit_q;
  logic [7:0]      rx_sh_q;
  logic            rx_done;
  logic            push;
  logic            pop;
  logic [CW-1:0]   cnt_q;
  logic [CW-1:0]   cnt_d;
  logic            validating_q;
  logic            validating_d;
  logic [7:0]      mem_q [RX_DEPTH];
  logic            rts_n_q;
  logic            rx_valid_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q   <= ISPFC_RX_IDLE;
      rx_tcnt_q <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
    end else if (clk_en) begin
      case (rx_st_q)
        ISPFC_RX_IDLE: begin
          rx_tcnt_q <= 4'h0;
          if (!rxd) begin
            rx_st_q <= ISPFC_RX_START;
          end
        end
        ISPFC_RX_START: begin
          if (tick_q) begin
            if (rx_tcnt_q == TICK_MID) begin
              // a glitch shorter than half a bit is not a start
              rx_tcnt_q <= 4'h0;
              rx_bit_q  <= 3'h0;
              rx_st_q   <= rxd ? ISPFC_RX_IDLE : ISPFC_RX_DATA;
            end else begin
              rx_tcnt_q <= rx_tcnt_q + 4'h1;
            end
          end
        end
        ISPFC_RX_DATA: begin
          if (tick_q) begin
            rx_tcnt_q <= rx_tcnt_q + 4'h1;
            if (rx_tcnt_q == TICK_LAST) begin
              rx_sh_q <= {rxd, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == LAST_BIT) begin
                rx_st_q <= ISPFC_RX_STOP;
              end
            end
          end
        end
        ISPFC_RX_STOP: begin
          if (tick_q) begin
            rx_tcnt_q <= rx_tcnt_q + 4'h1;
            if (rx_tcnt_q == TICK_LAST) begin
              rx_st_q <= ISPFC_RX_IDLE;
            end
          end
        end
        default: rx_st_q <= ISPFC_RX_IDLE;
      endcase
    end
  end
  // a character counts only with a mark stop bit; xon/xoff stay data
  assign rx_done = (rx_st_q == ISPFC_RX_STOP) && tick_q &&
                   (rx_tcnt_q == TICK_LAST) && rxd;
  assign pop  = rx_pop && rx_valid_q;
  // talk-only drops every incoming character, so no command is seen
  assign push = rx_done && !talk_only && (cnt_q != CNT_FULL || pop);
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    // a terminator stored with validate_done wins: the hold is set
    validating_d = (push && rx_sh_q == LINE_TERM) ||
                   (validating_q && !validate_done);
  end
  // head of the buffer is entry 0, so rx_data is a flop with no read mux
  for (genvar i = 0; i < RX_DEPTH; i++) begin : g_ent
    logic [7:0] nxt;
    if (i < RX_DEPTH - 1) begin : g_sh
      assign nxt = mem_q[i+1];
    end else begin : g_last
      assign nxt = mem_q[i];
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= 8'h00;
      end else if (clk_en) begin
        if (pop && push && CW'(i + 1) == cnt_q) begin
          mem_q[i] <= rx_sh_q;
        end else if (pop) begin
          mem_q[i] <= nxt;
        end else if (push && CW'(i) == cnt_q) begin
          mem_q[i] <= rx_sh_q;
        end
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q        <= '0;
      validating_q <= 1'b0;
      rx_valid_q   <= 1'b0;
      rts_n_q      <= 1'b0;
    end else if (clk_en) begin
      cnt_q        <= cnt_d;
      validating_q <= validating_d;
      rx_valid_q   <= (cnt_d != '0);
      // rts follows the next buffer state in the same edge
      rts_n_q      <= (cnt_d == CNT_FULL) || validating_d;
    end
  end
  // remote/local state
  logic remote_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_q <= 1'b0;
    end else if (clk_en) begin
      // the excluding modes win over entry, and entry over go_local
      remote_q <= !(talk_only || parallel_active) &&
                  (remote_enter || (remote_q && !go_local));
    end
  end
  // transmitter
  ispfc_tx_state_t tx_st_q;
  logic [3:0]      tx_tcnt_q;
  logic [2:0]      tx_bit_q;
  logic [7:0]      tx_sh_q;
  logic            txd_q;
  logic            tx_ready_q;
  logic            tx_go;
  // cts is looked at only here, at the start of a character
  // talk-only results leave through this same path
  assign tx_go = tx_valid && tx_ready_q && !cts_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q    <= ISPFC_TX_IDLE;
      tx_tcnt_q  <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= 8'h00;
      txd_q      <= 1'b1;
      tx_ready_q <= 1'b0;
    end else if (clk_en) begin
      case (tx_st_q)
        ISPFC_TX_IDLE: begin
          txd_q      <= 1'b1;
          tx_tcnt_q  <= 4'h0;
          tx_ready_q <= 1'b1;
          if (tx_go) begin
            tx_sh_q    <= tx_data;
            txd_q      <= 1'b0;
            tx_ready_q <= 1'b0;
            tx_st_q    <= ISPFC_TX_START;
          end
        end
        ISPFC_TX_START: begin
          if (tick_q) begin
            tx_tcnt_q <= tx_tcnt_q + 4'h1;
            if (tx_tcnt_q == TICK_LAST) begin
              txd_q    <= tx_sh_q[0];
              tx_bit_q <= 3'h0;
              tx_st_q  <= ISPFC_TX_DATA;
            end
          end
        end
        ISPFC_TX_DATA: begin
          if (tick_q) begin
            tx_tcnt_q <= tx_tcnt_q + 4'h1;
            if (tx_tcnt_q == TICK_LAST) begin
              tx_bit_q <= tx_bit_q + 3'h1;
              if (tx_bit_q == LAST_BIT) begin
                txd_q   <= 1'b1;
                tx_st_q <= ISPFC_TX_STOP;
              end else begin
                txd_q   <= tx_sh_q[1];
                tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              end
            end
          end
        end
        ISPFC_TX_STOP: begin
          if (tick_q) begin
            tx_tcnt_q <= tx_tcnt_q + 4'h1;
            if (tx_tcnt_q == TICK_LAST) begin
              tx_st_q <= ISPFC_TX_IDLE;
            end
          end
        end
        default: tx_st_q <= ISPFC_TX_IDLE;
      endcase
    end
  end
  assign txd      = txd_q;
  assign rts_n    = rts_n_q;
  assign remote   = remote_q;
  assign rx_data  = mem_q[0];
  assign rx_valid = rx_valid_q;
  assign tx_ready = tx_ready_q;
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_term_push;
    clk_en && push && rx_sh_q == LINE_TERM;
  endsequence
  sequence s_tx_launch;
    clk_en && tx_go ##1 !txd_q && tx_st_q == ISPFC_TX_START;
  endsequence
  chk_rts_when_full: assert property (
    cnt_q == CNT_FULL |-> rts_n_q)
    else $error("rts low while receive buffer full");
  chk_rts_free_slot: assert property (
    cnt_q != CNT_FULL && !validating_q |-> !rts_n_q)
    else $error("rts high although a slot is free");
  chk_rts_validate: assert property (
    s_term_push |=> rts_n_q && validating_q)
    else $error("rts not held after line terminator");
  chk_tx_launch: assert property (
    clk_en && tx_go |-> s_tx_launch)
    else $error("start bit not sent on cts low");
  chk_cts_idle_mark: assert property (
    tx_st_q == ISPFC_TX_IDLE && cts_n |=> tx_st_q == ISPFC_TX_IDLE && txd_q)
    else $error("character started while cts high");
  chk_frame_no_abort: assert property (
    tx_st_q == ISPFC_TX_DATA |=> tx_st_q inside {ISPFC_TX_DATA, ISPFC_TX_STOP})
    else $error("character cut short");
  chk_buf_full_drop: assert property (
    clk_en && rx_done && cnt_q == CNT_FULL && !pop |=> cnt_q == CNT_FULL)
    else $error("buffer count passed full");
  chk_baud_default: assert property (
    clk_en && settings_reset |=> baud_idx_q == RATE_IDX_RESET)
    else $error("settings reset did not select 9600");
  chk_remote_exclusive: assert property (
    clk_en && (parallel_active || talk_only) |=> !remote_q)
    else $error("serial remote while excluded");
  chk_stop_is_mark: assert property (
    tx_st_q == ISPFC_TX_STOP |-> txd_q)
    else $error("stop bit not at mark");
endmodule
`default_nettype wire

// ### tb/ispfc_host_model.sv
// host computer model: sends frames on rxd, decodes frames seen on txd
// assumes one bit lasts BIT_CYC ref_clk cycles, 8-N-1 frames
`timescale 1ns/100ps
`default_nettype none
module ispfc_host_model #(
  parameter int BIT_CYC = 1296
) (
  // clock
  input  wire logic ref_clk,
  // serial pins seen from the host
  output logic      rxd,
  input  wire logic txd,
  input  wire logic rts_n
);
  logic [7:0] got [$];
  logic [7:0] sh;
  bit         stalled; // rts never let a paced character go

  initial rxd = 1'b1; // line idles at mark

  // obey low models the three-wire host that ignores rts
  task automatic send(input logic [7:0] b, input bit obey);
    logic [9:0] fr;
    int         i;
    fr = {1'b1, b, 1'b0}; // start, lsb first, stop
    i = 0;
    while (obey && rts_n !== 1'b0 && i < 50000) begin // paced by rts
      @(posedge ref_clk);
      i++;
    end
    if (i >= 50000) stalled = 1'b1;
    for (i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      rxd <= fr[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask

  // mid-bit sampling; a frame with a bad stop bit is not kept
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      sh[k] = txd; // lsb first
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    if (txd === 1'b1) got.push_back(sh); // stop at mark
  end
endmodule
`default_nettype wire

// ### tb/instrument_serial_port_flow_ctrl_bench.sv
// bench for the serial port: host model on the pins, bench on the user side
// assumes 19200 baud for traffic so that the run stays short
`timescale 1ns/100ps
`default_nettype none
module instrument_serial_port_flow_ctrl_bench
  import ispfc_pkg::*;
;
  logic       ref_clk, rst_n, rxd, txd, rts_n, cts_n, remote;
  logic       baud_load, settings_reset, talk_only, parallel_active;
  logic       remote_enter, go_local, rx_valid, rx_pop, validate_done;
  logic       tx_valid, tx_ready;
  logic [3:0] baud_sel;
  logic [7:0] rx_data, tx_data, tb0, tb1;
  logic [7:0] exp_q [4];
  logic [4:0] tab [8];
  int         bad_count, compares, w;

  ispfc_serial_port u_ispfc_serial_port (
    .ref_clk, .rst_n, .clk_en(1'b1), .rxd, .txd, .rts_n, .cts_n,
    .baud_sel, .baud_load, .settings_reset, .talk_only, .parallel_active,
    .remote_enter, .go_local, .remote, .rx_data, .rx_valid, .rx_pop,
    .validate_done, .tx_data, .tx_valid, .tx_ready
  );
  ispfc_host_model #(.BIT_CYC(1296)) u_ispfc_host_model (
    .ref_clk, .rxd, .txd, .rts_n
  );

  always #20 ref_clk = ~ref_clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rng(input string n, input int lo, input int hi,
                         input int g);
    compares++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  task automatic final_report;
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      chk("wait bound", 8'h00, 8'hFF);
      final_report;
    end
  endtask

  // sel 0: transmitter idle, else: host has both bytes
  task automatic wait_until(input int sel, input int lim);
    int n;
    n = 0;
    while (!(sel == 0 ? tx_ready === 1'b1
                      : u_ispfc_host_model.got.size() == 2) && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    bound(n, lim);
  endtask

  // hold > 0 keeps cts high that long before releasing it; w = start width
  task automatic tx_send(input logic [7:0] d, input int hold);
    int n;
    @(posedge ref_clk);
    tx_data  <= d;
    tx_valid <= 1'b1;
    if (hold > 0) begin
      repeat (hold) @(posedge ref_clk);
      chk("txd while cts high", 8'h01, 8'(txd));
      chk("tx_ready while cts high", 8'h01, 8'(tx_ready));
      cts_n <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(tx_ready === 1'b1 && cts_n === 1'b0) && n < 30000);
    tx_valid <= 1'b0;
    bound(n, 30000);
    #1;
    w = 0;
    while (txd === 1'b0 && w < 4000) begin
      @(posedge ref_clk);
      #1;
      w++;
    end
  endtask

  initial begin
    {ref_clk, rst_n, cts_n, baud_load, settings_reset} = '0;
    {talk_only, parallel_active, remote_enter, go_local} = '0;
    {rx_pop, validate_done, tx_valid} = '0;
    baud_sel = 4'h9;
    tx_data = 8'h00;
    bad_count = 0;
    compares = 0;
    // {talk_only, parallel_active, remote_enter, go_local, expected}
    tab = '{5'b00101, 5'b00010, 5'b00111, 5'b10000,
            5'b00101, 5'b01000, 5'b01100, 5'b00010};
    void'($urandom(32'hA1B6));
    exp_q = '{8'($urandom_range(126, 32)), 8'h13,
              8'($urandom_range(126, 32)), 8'h11};
    tb0 = 8'($urandom) | 8'h01; // lsb set: start width ends at bit 0
    tb1 = 8'($urandom);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    baud_load <= 1'b1; // fastest rate
    @(posedge ref_clk);
    baud_sel <= 4'hF; // out of range, must be ignored
    @(posedge ref_clk);
    baud_load <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {talk_only, parallel_active, remote_enter, go_local} <= tab[i][4:1];
      @(posedge ref_clk);
      remote_enter <= 1'b0;
      go_local     <= 1'b0;
      #1;
      chk("remote", 8'(tab[i][0]), 8'(remote));
    end
    fork
      begin
        tx_send(tb0, 0);
        chk_rng("tx start cycles", 1216, 1296, w);
        cts_n <= 1'b1; // raised mid-frame
        wait_until(0, 20000);
        tx_send(tb1, 300);
        wait_until(1, 30000);
        chk("tx byte 0", tb0, u_ispfc_host_model.got[0]);
        chk("tx byte 1", tb1, u_ispfc_host_model.got[1]);
      end
      begin
        for (int k = 0; k < 4; k++) begin
          chk("rts ready", 8'h00, 8'(rts_n));
          u_ispfc_host_model.send(exp_q[k], 1'b1);
          bound(int'(u_ispfc_host_model.stalled), 1);
          chk("rx_valid", 8'h01, 8'(rx_valid));
        end
        chk("rts when full", 8'h01, 8'(rts_n));
        u_ispfc_host_model.send(8'($urandom), 1'b0);
        @(posedge ref_clk);
        rx_pop <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          @(posedge ref_clk);
          chk("rx_data", exp_q[k], rx_data);
          if (k == 3) rx_pop <= 1'b0;
          #1;
          if (k == 0) chk("rts after pop", 8'h00, 8'(rts_n));
        end
        chk("rx empty", 8'h00, 8'(rx_valid));
        u_ispfc_host_model.send(LINE_TERM, 1'b1);
        bound(int'(u_ispfc_host_model.stalled), 1);
        chk("rts after term", 8'h01, 8'(rts_n));
        chk("term data", LINE_TERM, rx_data);
        @(posedge ref_clk);
        rx_pop <= 1'b1;
        @(posedge ref_clk);
        rx_pop <= 1'b0;
        @(posedge ref_clk);
        chk("rts validating", 8'h01, 8'(rts_n));
        validate_done <= 1'b1;
        @(posedge ref_clk);
        validate_done <= 1'b0;
        #1;
        chk("rts validated", 8'h00, 8'(rts_n));
      end
    join
    @(posedge ref_clk);
    settings_reset <= 1'b1; // back to the default rate
    @(posedge ref_clk);
    settings_reset <= 1'b0;
    tx_send(8'h01, 0);
    chk_rng("default start cycles", 2431, 2592, w);
    // reset in mid-frame, during data bit 0
    rst_n <= 1'b0;
    #1;
    chk("pins in reset", 8'h08,
        {4'h0, txd, rts_n, remote, rx_valid});
    final_report;
  end
endmodule
`default_nettype wire
